//--- slt_light_timer.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module slt_light_timer #(
	parameter int unsigned BASE_CYC = slt_pkg::BASE_TICK_CYC,
	parameter int unsigned SCAN_CYC = slt_pkg::SCAN_CYC
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  slt_pkg::slt_bus_req_t     bus_req,
	output logic [31:0]               rd_data,
	input  wire logic                 trigger_input,
	input  wire logic                 clear_input,
	input  slt_pkg::slt_params_t      live_params,
	input  wire logic                 power_restore,
	output logic                      switch_output,
	output logic                      warn_active
);

	// Configuration registers
	logic [slt_pkg::CTRL_WIDTH-1:0] ctrl_q;
	slt_pkg::slt_params_t           stored_q;
	slt_pkg::slt_params_t           eff;
	slt_pkg::slt_timebase_t         timebase;
	logic                           multi_mode;
	logic                           retrig_en;
	logic                           warn_en;
	logic                           retain_en;
	logic [3:0]                     live_sel;

	// Timer state
	slt_pkg::slt_state_t state_q;
	slt_pkg::slt_state_t state_d;
	logic [15:0]         elapsed_q;
	logic [15:0]         elapsed_d;
	logic                counting;
	logic                trg_now;
	logic                clr_now;
	logic                trg_prev_q;
	logic                trg_rise;
	logic                trg_fall;
	logic                unit_tick;
	logic                scan_tick;
	logic                warn_d;
	logic                out_d;
	logic [15:0]         warn_ofs;
	logic [15:0]         warn_len;
	logic [16:0]         warn_begin;
	logic [16:0]         warn_end;

	assign multi_mode = ctrl_q[slt_pkg::CTRL_MULTI_BIT];
	assign retrig_en  = ctrl_q[slt_pkg::CTRL_RETRIG_BIT];
	assign warn_en    = ctrl_q[slt_pkg::CTRL_WARN_BIT];
	assign retain_en  = ctrl_q[slt_pkg::CTRL_RETAIN_BIT];
	assign live_sel   = ctrl_q[slt_pkg::CTRL_LIVE_LSB +: 4];
	assign timebase   = slt_pkg::slt_timebase_t'(ctrl_q[slt_pkg::CTRL_TB_LSB +: 2]);

	// Pins come from outside the clock domain
	slt_sync #(
		.WIDTH(2)
	) u_sync (
		.clock   (clock),
		.rst     (rst),
		.async_in({clear_input, trigger_input}),
		.sync_out({clr_now, trg_now})
	);

	// Scan strobe and time-base unit tick
	slt_tick #(
		.BASE_CYC(BASE_CYC),
		.SCAN_CYC(SCAN_CYC)
	) u_tick (
		.clock    (clock),
		.rst      (rst),
		.timebase (timebase),
		.unit_tick(unit_tick),
		.scan_tick(scan_tick)
	);

	// Register writes; one select bit per timing value
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_q   <= slt_pkg::CTRL_RESET;
			stored_q <= '{default: slt_pkg::VALUE_RESET};
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				slt_pkg::OFS_CTRL:        ctrl_q <= bus_req.wdata[slt_pkg::CTRL_WIDTH-1:0];
				slt_pkg::OFS_OFF_DELAY:   stored_q.off_delay   <= bus_req.wdata[15:0];
				slt_pkg::OFS_WARN_OFFSET: stored_q.warn_offset <= bus_req.wdata[15:0];
				slt_pkg::OFS_WARN_LENGTH: stored_q.warn_length <= bus_req.wdata[15:0];
				slt_pkg::OFS_HOLD:        stored_q.hold        <= bus_req.wdata[15:0];
				default: ;
			endcase
		end
	end

	// Live source of each value is picked per field
	always_comb begin
		eff.off_delay   = live_sel[0] ? live_params.off_delay   : stored_q.off_delay;
		eff.warn_offset = live_sel[1] ? live_params.warn_offset : stored_q.warn_offset;
		eff.warn_length = live_sel[2] ? live_params.warn_length : stored_q.warn_length;
		eff.hold        = live_sel[3] ? live_params.hold        : stored_q.hold;
	end

	// A zero warn value means the time-base default
	always_comb begin
		warn_ofs = eff.warn_offset;
		warn_len = eff.warn_length;
		if (eff.warn_offset == 16'h0000) begin
			case (timebase)
				slt_pkg::TB_SECONDS: warn_ofs = slt_pkg::WARN_OFS_SEC;
				slt_pkg::TB_MINUTES: warn_ofs = slt_pkg::WARN_OFS_MIN;
				default:             warn_ofs = slt_pkg::WARN_OFS_HR;
			endcase
		end
		if (eff.warn_length == 16'h0000) begin
			case (timebase)
				slt_pkg::TB_SECONDS: warn_len = slt_pkg::WARN_LEN_SEC;
				slt_pkg::TB_MINUTES: warn_len = slt_pkg::WARN_LEN_MIN;
				default:             warn_len = slt_pkg::WARN_LEN_HR;
			endcase
		end
	end

	// Previous scan sample of the trigger
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trg_prev_q <= 1'b0;
		end else if (scan_tick) begin
			trg_prev_q <= trg_now;
		end
	end

	// Edges only count on the scan strobe
	assign trg_rise = scan_tick && trg_now && !trg_prev_q;
	assign trg_fall = scan_tick && !trg_now && trg_prev_q;

	// Timer counts while holding (multi) or running the off-delay
	assign counting = (state_q == slt_pkg::ST_RUN)
		|| (multi_mode && state_q == slt_pkg::ST_HELD);

	// Warn window in units: T - offset up to T - offset + length
	// Offset above T starts the warning at once; saturates at zero
	always_comb begin
		if ({1'b0, warn_ofs} > {1'b0, eff.off_delay}) begin
			warn_begin = 17'h0_0000;
		end else begin
			warn_begin = {1'b0, eff.off_delay} - {1'b0, warn_ofs};
		end
		warn_end = warn_begin + {1'b0, warn_len};
	end

	// Main sequence
	always_comb begin
		state_d   = state_q;
		elapsed_d = elapsed_q;
		if (counting && unit_tick && elapsed_q != 16'hFFFF) begin
			elapsed_d = elapsed_q + 16'h0001;
		end
		case (state_q)
			slt_pkg::ST_IDLE: begin
				if (trg_rise) begin
					state_d   = slt_pkg::ST_HELD;
					elapsed_d = 16'h0000;
				end
			end
			slt_pkg::ST_HELD: begin
				if (trg_fall) begin
					state_d   = slt_pkg::ST_RUN;
					elapsed_d = 16'h0000;
				end else if (multi_mode && elapsed_q >= eff.hold) begin
					state_d = slt_pkg::ST_PERM;
				end
			end
			slt_pkg::ST_RUN: begin
				if (multi_mode && trg_rise) begin
					state_d   = slt_pkg::ST_IDLE;
					elapsed_d = 16'h0000;
				end else if (!multi_mode && retrig_en && trg_fall) begin
					elapsed_d = 16'h0000;
				end else if (elapsed_q >= eff.off_delay) begin
					state_d = slt_pkg::ST_IDLE;
				end
			end
			slt_pkg::ST_PERM: begin
				if (!multi_mode || trg_rise) begin
					state_d   = slt_pkg::ST_IDLE;
					elapsed_d = 16'h0000;
				end
			end
			default: begin
				state_d   = slt_pkg::ST_IDLE;
				elapsed_d = 16'h0000;
			end
		endcase
		// In multi mode, clear dominates any trigger edge in the same scan
		if (multi_mode && clr_now) begin
			state_d   = slt_pkg::ST_IDLE;
			elapsed_d = 16'h0000;
		end
		// Power return without retention drops state
		if (power_restore && !retain_en) begin
			state_d   = slt_pkg::ST_IDLE;
			elapsed_d = 16'h0000;
		end
	end

	// Pre-warning blanks the output inside its window
	always_comb begin
		warn_d = warn_en && (state_d == slt_pkg::ST_RUN)
			&& ({1'b0, elapsed_d} >= warn_begin)
			&& ({1'b0, elapsed_d} < warn_end);
		out_d  = (state_d != slt_pkg::ST_IDLE) && !warn_d;
	end

	// State and elapsed time
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q   <= slt_pkg::ST_IDLE;
			elapsed_q <= 16'h0000;
		end else begin
			state_q   <= state_d;
			elapsed_q <= elapsed_d;
		end
	end

	// Outputs straight from flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			switch_output <= 1'b0;
			warn_active   <= 1'b0;
		end else begin
			switch_output <= out_d;
			warn_active   <= warn_d;
		end
	end

	// Read data valid the cycle after the strobe only
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data <= 32'h0000_0000;
		end else if (bus_req.rd) begin
			case (bus_req.addr)
				slt_pkg::OFS_CTRL:        rd_data <= {22'h00_0000, ctrl_q};
				slt_pkg::OFS_OFF_DELAY:   rd_data <= {16'h0000, stored_q.off_delay};
				slt_pkg::OFS_WARN_OFFSET: rd_data <= {16'h0000, stored_q.warn_offset};
				slt_pkg::OFS_WARN_LENGTH: rd_data <= {16'h0000, stored_q.warn_length};
				slt_pkg::OFS_HOLD:        rd_data <= {16'h0000, stored_q.hold};
				slt_pkg::OFS_STATUS:      rd_data <= {28'h000_0000,
					state_q == slt_pkg::ST_PERM, warn_active,
					state_q == slt_pkg::ST_RUN, switch_output};
				slt_pkg::OFS_ELAPSED:     rd_data <= {16'h0000, elapsed_q};
				default:                  rd_data <= 32'h0000_0000;
			endcase
		end else begin
			rd_data <= 32'h0000_0000;
		end
	end

endmodule

//--- slt_light_timer_monitor.sv
`timescale 1ns/1ps
module slt_light_timer_monitor (
	input wire logic             clock,
	input wire logic             rst,
	input slt_pkg::slt_bus_req_t bus_req,
	input wire logic [31:0]      rd_data,
	input wire logic             trigger_input,
	input wire logic             clear_input,
	input slt_pkg::slt_params_t  live_params,
	input wire logic             power_restore,
	input wire logic             switch_output,
	input wire logic             warn_active
);
	logic [9:0] ctrl_q;
	logic [4:0] trig_age_q;
	logic [4:0] clr_cnt_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Shadow of the mode register, seen from the write strobe
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			ctrl_q <= '0;
		else if (bus_req.wr && bus_req.addr == slt_pkg::OFS_CTRL)
			ctrl_q <= bus_req.wdata[9:0];
	end
	// Cycles since trigger was last high, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			trig_age_q <= 5'h1F;
		else if (trigger_input)
			trig_age_q <= '0;
		else if (trig_age_q != 5'h1F)
			trig_age_q <= trig_age_q + 5'h01;
	end
	// Length of the current clear level, saturating
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			clr_cnt_q <= '0;
		else if (!clear_input)
			clr_cnt_q <= '0;
		else if (clr_cnt_q != 5'h1F)
			clr_cnt_q <= clr_cnt_q + 5'h01;
	end
	sequence s_rd_at(logic [7:0] a);
		$past(bus_req.rd) && $past(bus_req.addr) == a;
	endsequence
	a_rd_idle_zero: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0000_0000)
		else $error("read data not zero outside read");
	a_unmapped_zero: assert property ($past(bus_req.rd) && $past(bus_req.addr) > 8'h18
		|-> rd_data == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ctrl_readback: assert property (s_rd_at(slt_pkg::OFS_CTRL)
		|-> rd_data == {22'h00_0000, $past(ctrl_q)})
		else $error("control readback wrong");
	a_status_mirror: assert property (s_rd_at(slt_pkg::OFS_STATUS) |-> rd_data[0]
		== $past(switch_output) && rd_data[2] == $past(warn_active))
		else $error("status does not mirror outputs");
	a_warn_blanks: assert property (warn_active |-> !switch_output)
		else $error("output high during warning");
	a_warn_enabled: assert property ($rose(warn_active) |-> ctrl_q[2])
		else $error("warning without enable");
	a_rise_cause: assert property ($rose(switch_output) && !$past(warn_active)
		|-> trig_age_q < 5'd12)
		else $error("output rose without trigger");
	a_clear_low: assert property (ctrl_q[0] && clr_cnt_q >= 5'd10
		|-> !switch_output)
		else $error("output high under clear");
	a_power_drop: assert property (power_restore && !ctrl_q[3]
		|-> ##[1:2] !switch_output)
		else $error("output kept after power loss");
	a_retain_keep: assert property (power_restore && ctrl_q[3]
		&& switch_output && !warn_active |=> switch_output)
		else $error("retained output lost");
endmodule
bind slt_light_timer slt_light_timer_monitor u_mon (
	.clock         (clock),
	.rst           (rst),
	.bus_req       (bus_req),
	.rd_data       (rd_data),
	.trigger_input (trigger_input),
	.clear_input   (clear_input),
	.live_params   (live_params),
	.power_restore (power_restore),
	.switch_output (switch_output),
	.warn_active   (warn_active)
);

//--- slt_light_timer_tb.sv
`timescale 1ns/1ps
module slt_light_timer_tb;
	localparam int U = 20;
	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	slt_pkg::slt_bus_req_t bus_req = '0;
	slt_pkg::slt_params_t  live_params = '0;
	logic                  power_restore = 1'b0;
	logic [31:0]           rd_data;
	logic                  trigger_input;
	logic                  clear_input;
	logic                  switch_output;
	logic                  warn_active;
	int                    n_mismatch = 0;
	int                    n_checks = 0;
	int                    cyc = 0;
	always #2.5 clock = ~clock;
	// Short scan keeps the seconds base meaningful
	slt_light_timer #(.BASE_CYC(U), .SCAN_CYC(4)) uut (
		.clock(clock), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
		.trigger_input(trigger_input), .clear_input(clear_input),
		.live_params(live_params), .power_restore(power_restore),
		.switch_output(switch_output), .warn_active(warn_active));
	slt_src src (.clock(clock), .trigger_input(trigger_input), .clear_input(clear_input));
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Hang guard, well above the longest scenario chain
	always @(posedge clock) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask
	task automatic chk_rng(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi) begin
			n_mismatch++;
			$display("[ERR] %0t delay %0d not in %0d..%0d", $time, v, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: {16'h0000, d}, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus_req.wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus_req.rd <= 1'b0;
		#1;
		d = rd_data;
	endtask
	task automatic cfg(input logic [15:0] c, t, o, l, h);
		wr(slt_pkg::OFS_CTRL, c);
		wr(slt_pkg::OFS_OFF_DELAY, t);
		wr(slt_pkg::OFS_WARN_OFFSET, o);
		wr(slt_pkg::OFS_WARN_LENGTH, l);
		wr(slt_pkg::OFS_HOLD, h);
	endtask
	// Cycles until output (w=0) or warning (w=1) reaches v
	// Looks just after each edge so a value launched by that edge is settled
	task automatic wait_for(input bit w, input logic v, input int max, output int n);
		n = 0;
		#1;
		while (((w ? warn_active : switch_output) !== v) && n < max) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask
	task automatic pwr();
		@(posedge clock);
		power_restore <= 1'b1;
		@(posedge clock);
		power_restore <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic t_regs();
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			rd(8'(i * 4), d);
			chk(d, 32'h0000_0000);
		end
		wr(slt_pkg::OFS_CTRL, 16'h02EE);
		rd(slt_pkg::OFS_CTRL, d);
		chk(d, 32'h0000_02EE);
		wr(slt_pkg::OFS_HOLD, 16'hBEEF);
		rd(slt_pkg::OFS_HOLD, d);
		chk(d, 32'h0000_BEEF);
		wr(slt_pkg::OFS_STATUS, 16'h000F);
		rd(slt_pkg::OFS_STATUS, d);
		chk(d, 32'h0000_0000);
		wr(8'h20, 16'h1234);
		rd(8'h20, d);
		chk(d, 32'h0000_0000);
	endtask
	task automatic t_stair(input logic [15:0] c);
		logic [31:0] d;
		int n;
		// Longer delay with retrigger so the first run cannot end before the refire
		cfg(c, c[1] ? 16'h0007 : 16'h0005, 16'h0000, 16'h0000, 16'h0000);
		src.pulse(12, 2'b01);
		chk1(switch_output, 1'b1);
		repeat (3 * U) @(posedge clock);
		chk1(switch_output, 1'b1);
		rd(slt_pkg::OFS_ELAPSED, d);
		chk1(d >= 32'd2 && d <= 32'd4, 1'b1);
		if (c[1]) begin
			src.pulse(6, 2'b01);
			repeat (4 * U) @(posedge clock);
			chk1(switch_output, 1'b1);
		end
		wait_for(0, 0, 5 * U, n);
		chk_rng(n, 0, c[1] ? 4 * U : 3 * U);
	endtask
	task automatic t_warn(input logic [15:0] c, o, l, input int t, m, eo, el);
		int n;
		cfg(c, 16'(t), o, l, 16'h0000);  // one time base for all values
		src.pulse(12, 2'b01);
		wait_for(1, 1, (t - eo + 1) * m + 20, n);
		chk_rng(n, (t - eo - 1) * m, (t - eo) * m + 10);
		chk1(switch_output, 1'b0);
		wait_for(1, 0, (el + 1) * m, n);
		chk_rng(n, el * m - 10, el * m + 10);
		chk1(switch_output, 1'b1);
		wait_for(0, 0, (eo - el + 1) * m + 20, n);
		chk_rng(n, (eo - el - 1) * m, (eo - el) * m + 10);
	endtask
	task automatic t_live();
		logic [31:0] d;
		int n;
		cfg(16'h0040, 16'h0032, 16'h0000, 16'h0000, 16'h0032);
		live_params <= {16'h0002, 32'h0000_0000, 16'h0004};
		src.pulse(12, 2'b01);
		wait_for(0, 0, 8 * U, n);
		chk_rng(n, 3 * U, 4 * U + 10);
		wr(slt_pkg::OFS_CTRL, 16'h0241);
		src.pulse(4 * U, 2'b01);
		repeat (6 * U) @(posedge clock);
		chk1(switch_output, 1'b1);
		rd(slt_pkg::OFS_STATUS, d);
		chk(d & 32'h0000_0009, 32'h0000_0009);
		src.pulse(12, 2'b01);
		chk1(switch_output, 1'b0);
		repeat (2 * U) @(posedge clock);
		chk1(switch_output, 1'b0);
	endtask
	task automatic t_multi();
		logic [31:0] d;
		int n;
		cfg(16'h0001, 16'h0005, 16'h0000, 16'h0000, 16'h0003);
		src.pulse(12, 2'b01);
		repeat (2 * U) @(posedge clock);
		chk1(switch_output, 1'b1);
		src.pulse(12, 2'b01);
		chk1(switch_output, 1'b0);
		src.pulse(12, 2'b01);
		wait_for(0, 0, 8 * U, n);
		chk_rng(n, 4 * U, 6 * U + 10);
		src.pulse(12, 2'b01);
		repeat (U) @(posedge clock);
		src.pulse(12, 2'b10);
		chk1(switch_output, 1'b0);
		rd(slt_pkg::OFS_ELAPSED, d);
		chk(d, 32'h0000_0000);
		src.pulse(12, 2'b11);
		repeat (U) @(posedge clock);
		chk1(switch_output, 1'b0);
	endtask
	task automatic t_power();
		logic [31:0] d;
		int n;
		cfg(16'h0000, 16'h000A, 16'h0000, 16'h0000, 16'h0000);
		src.pulse(12, 2'b01);
		repeat (U) @(posedge clock);
		pwr();
		chk1(switch_output, 1'b0);
		rd(slt_pkg::OFS_ELAPSED, d);
		chk(d, 32'h0000_0000);
		wr(slt_pkg::OFS_CTRL, 16'h0008);
		src.pulse(12, 2'b01);
		repeat (U) @(posedge clock);
		pwr();
		chk1(switch_output, 1'b1);
		wait_for(0, 0, 14 * U, n);
		chk_rng(n, 7 * U, 9 * U + 10);
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_stair(16'h0000);
		t_stair(16'h0002);
		t_warn(16'h0004, 16'h0006, 16'h0003, 20, U, 6, 3);
		t_warn(16'h0004, 16'h0000, 16'h0000, 100, U, 75, 5);
		t_warn(16'h0014, 16'h0000, 16'h0000, 16, 100 * U, 15, 1);
		t_live();
		t_multi();
		t_power();
		report_and_stop();
	end
endmodule

//--- slt_pkg.sv
package slt_pkg;

	// Clock and timing
	localparam int unsigned CLK_PERIOD_PS  = 5000;
	localparam int unsigned BASE_TICK_US   = 10000;
	localparam int unsigned BASE_TICK_CYC  = (BASE_TICK_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int unsigned SCAN_US        = 1000;
	localparam int unsigned SCAN_CYC       = (SCAN_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int unsigned TICKS_PER_SEC  = 100;
	localparam int unsigned SECS_PER_MIN   = 60;

	// Register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_OFF_DELAY   = 8'h04;
	localparam logic [7:0] OFS_WARN_OFFSET = 8'h08;
	localparam logic [7:0] OFS_WARN_LENGTH = 8'h0C;
	localparam logic [7:0] OFS_HOLD        = 8'h10;
	localparam logic [7:0] OFS_STATUS      = 8'h14;
	localparam logic [7:0] OFS_ELAPSED     = 8'h18;

	// Control field positions
	localparam int unsigned CTRL_MULTI_BIT   = 0;
	localparam int unsigned CTRL_RETRIG_BIT  = 1;
	localparam int unsigned CTRL_WARN_BIT    = 2;
	localparam int unsigned CTRL_RETAIN_BIT  = 3;
	localparam int unsigned CTRL_TB_LSB      = 4;
	localparam int unsigned CTRL_LIVE_LSB    = 6;
	localparam int unsigned CTRL_WIDTH       = 10;

	// Reset values
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET  = 10'h000;
	localparam logic [15:0]           VALUE_RESET = 16'h0000;

	// Default pre-warning in time-base units (seconds base counts 10 ms units)
	localparam logic [15:0] WARN_OFS_SEC = 16'h004B;
	localparam logic [15:0] WARN_LEN_SEC = 16'h0005;
	localparam logic [15:0] WARN_OFS_MIN = 16'h000F;
	localparam logic [15:0] WARN_LEN_MIN = 16'h0001;
	localparam logic [15:0] WARN_OFS_HR  = 16'h000F;
	localparam logic [15:0] WARN_LEN_HR  = 16'h0001;

	typedef enum logic [1:0] {
		TB_SECONDS,
		TB_MINUTES,
		TB_HOURS
	} slt_timebase_t;

	typedef enum {
		ST_IDLE,
		ST_HELD,
		ST_RUN,
		ST_PERM
	} slt_state_t;

	// Timing parameters, either stored or live
	typedef struct packed {
		logic [15:0] hold;
		logic [15:0] warn_length;
		logic [15:0] warn_offset;
		logic [15:0] off_delay;
	} slt_params_t;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} slt_bus_req_t;

endpackage

//--- slt_src.sv
`timescale 1ns/1ps
// Program logic that drives the trigger and clear pins
module slt_src (
	input  wire logic clock,
	output logic      trigger_input,
	output logic      clear_input
);
	initial begin
		trigger_input = 1'b0;
		clear_input   = 1'b0;
	end
	// Gap first, so two pulses never merge inside one scan
	task automatic pulse(input int n, input logic [1:0] v);
		repeat (8) @(posedge clock);
		trigger_input <= v[0];
		clear_input   <= v[1];
		repeat (n) @(posedge clock);
		trigger_input <= 1'b0;
		clear_input   <= 1'b0;
	endtask
endmodule

//--- slt_sync.sv
`timescale 1ns/1ps
module slt_sync #(
	parameter int unsigned WIDTH = 2
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// Two stages per pin; first stage feeds only the second
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				meta_q[i]   <= 1'b0;
				sync_out[i] <= 1'b0;
			end else begin
				meta_q[i]   <= async_in[i];
				sync_out[i] <= meta_q[i];
			end
		end
	end

endmodule

//--- slt_tick.sv
`timescale 1ns/1ps
module slt_tick #(
	parameter int unsigned BASE_CYC = slt_pkg::BASE_TICK_CYC,
	parameter int unsigned SCAN_CYC = slt_pkg::SCAN_CYC
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  slt_pkg::slt_timebase_t     timebase,
	output logic                       unit_tick,
	output logic                       scan_tick
);

	logic [31:0] base_cnt_q;
	logic [31:0] scan_cnt_q;
	logic [6:0]  sec_cnt_q;
	logic [5:0]  min_cnt_q;
	logic        base_tick;
	logic        sec_tick;
	logic        min_tick;

	assign base_tick = (base_cnt_q == 32'(BASE_CYC - 1));
	assign sec_tick  = base_tick && (sec_cnt_q == 7'(slt_pkg::TICKS_PER_SEC - 1));
	assign min_tick  = sec_tick && (min_cnt_q == 6'(slt_pkg::SECS_PER_MIN - 1));

	// 10 ms prescaler
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			base_cnt_q <= 32'h0000_0000;
		end else begin
			base_cnt_q <= base_tick ? 32'h0000_0000 : base_cnt_q + 32'h0000_0001;
		end
	end

	// Seconds and minutes chain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sec_cnt_q <= 7'h00;
			min_cnt_q <= 6'h00;
		end else begin
			if (base_tick) begin
				sec_cnt_q <= sec_tick ? 7'h00 : sec_cnt_q + 7'h01;
			end
			if (sec_tick) begin
				min_cnt_q <= min_tick ? 6'h00 : min_cnt_q + 6'h01;
			end
		end
	end

	// Scan-cycle strobe for edge sampling
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scan_cnt_q <= 32'h0000_0000;
			scan_tick  <= 1'b0;
		end else begin
			scan_tick  <= (scan_cnt_q == 32'(SCAN_CYC - 1));
			scan_cnt_q <= (scan_cnt_q == 32'(SCAN_CYC - 1)) ? 32'h0000_0000
				: scan_cnt_q + 32'h0000_0001;
		end
	end

	// One time-base unit per selected period
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			unit_tick <= 1'b0;
		end else begin
			case (timebase)
				slt_pkg::TB_SECONDS: unit_tick <= base_tick;
				slt_pkg::TB_MINUTES: unit_tick <= sec_tick;
				slt_pkg::TB_HOURS:   unit_tick <= min_tick;
				default:             unit_tick <= 1'b0;
			endcase
		end
	end

endmodule
